//--- hdl/ldm_defs.vh
`ifndef LDM_DEFS_VH
`define LDM_DEFS_VH
`define LDM_ADDR_W 8
`define LDM_OFF_RXEXT 8'h54
`define LDM_OFF_LOOP 8'h58
`define LDM_OFF_SLIP 8'h5C
`define LDM_OFF_IRQST 8'h70
`define LDM_OFF_IRQMSK 8'h74
`define LDM_RXBUF_DEPTH 4
`define LDM_PER_HI 31
`define LDM_PER_LO 24
`define LDM_FRESH_BIT 23
`define LDM_LOOP_W 20
`define LDM_RXSLIP_HI 20
`define LDM_RXSLIP_LO 16
`define LDM_TXEN_BIT 5
`define LDM_SLIP_W 5
`define LDM_IRQ_W 3
`define LDM_IRQ_EXT 0
`define LDM_IRQ_LOOP 1
`define LDM_IRQ_SLIP 2
`define LDM_RESP_OKAY 2'h0
`define LDM_RESP_SLVERR 2'h2
`endif

//--- hdl/ldm_event_flags.v
`timescale 1ns/1ns
`include "ldm_defs.vh"
module ldm_event_flags
(
  // clock and reset
  input wire clk,
  input wire resetn,
  // events and software access
  input wire [`LDM_IRQ_W-1:0] evtSet,
  input wire [`LDM_IRQ_W-1:0] clrMask,
  input wire clrStrobe,
  input wire [`LDM_IRQ_W-1:0] maskVal,
  // flags and line
  output reg [`LDM_IRQ_W-1:0] status_r,
  output wire irq
);
  // set wins over a clear in the same cycle
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      status_r <= {`LDM_IRQ_W{1'b0}};
    else
      status_r <= (status_r & ~(clrStrobe ? clrMask : {`LDM_IRQ_W{1'b0}})) | evtSet;
  end
  assign irq = |(status_r & maskVal);
endmodule // ldm_event_flags

//--- hdl/ldm_regs.v
`timescale 1ns/1ns
`include "ldm_defs.vh"
module ldm_regs
(
  // clock and reset
  input wire clk,
  input wire resetn,
  // axi4-lite write
  input wire [`LDM_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [`LDM_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // extended latency measurement
  input wire rxExtResultStrobe,
  input wire [`LDM_RXBUF_DEPTH-1:0] rxExtResultValue,
  output wire [7:0] rxMeasurePeriod,
  // loop latency
  input wire txFramePulse,
  input wire rxFramePulse,
  // transceiver slip
  input wire frameSyncReset,
  input wire alignActive,
  input wire commaMoved,
  input wire [`LDM_SLIP_W-1:0] rxSlipDetected,
  output wire txSlipEnable,
  output wire [`LDM_SLIP_W-1:0] txSlipAmount,
  // interrupt
  output wire irq
);
  ////////////////////////////////////////////////////////////////
  reg [7:0] period_r;
  reg fresh_r;
  reg [`LDM_RXBUF_DEPTH-1:0] extLat_r;
  reg [`LDM_LOOP_W-1:0] loopCnt_r;
  reg [`LDM_LOOP_W-1:0] loopLat_r;
  reg loopRun_r;
  reg [`LDM_SLIP_W-1:0] rxSlip_r;
  reg txEn_r;
  reg [`LDM_SLIP_W-1:0] txSlip_r;
  reg [`LDM_IRQ_W-1:0] mask_r;
  reg awHeld_r;
  reg [`LDM_ADDR_W-1:0] awAddr_r;
  reg wHeld_r;
  reg [31:0] wData_r;
  reg [3:0] wStrb_r;
  wire [`LDM_IRQ_W-1:0] status;
  wire doWrite;
  wire doRead;
  wire slipUpdate;
  wire loopDone;
  reg [31:0] rdWord;
  reg rdHit;

  // merges a write into a word honouring byte strobes
  function [31:0] strobeMerge;
    input [31:0] oldV;
    input [31:0] newV;
    input [3:0] strb;
    integer i;
    begin
      strobeMerge = oldV;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          strobeMerge[i*8 +: 8] = newV[i*8 +: 8];
    end
  endfunction

  // true when an address selects a given register word
  function hitOff;
    input [`LDM_ADDR_W-1:0] addr;
    input [`LDM_ADDR_W-1:0] off;
    begin
      hitOff = (addr[`LDM_ADDR_W-1:2] == off[`LDM_ADDR_W-1:2]);
    end
  endfunction

  // true for any of the five register words
  function isMapped;
    input [`LDM_ADDR_W-1:0] addr;
    begin
      isMapped = hitOff(addr, `LDM_OFF_RXEXT) || hitOff(addr, `LDM_OFF_LOOP)
        || hitOff(addr, `LDM_OFF_SLIP) || hitOff(addr, `LDM_OFF_IRQST)
        || hitOff(addr, `LDM_OFF_IRQMSK);
    end
  endfunction

  // zero fills between the fields of each word
  localparam EXT_PAD_W = `LDM_FRESH_BIT - `LDM_RXBUF_DEPTH;
  localparam LOOP_PAD_W = 32 - `LDM_LOOP_W;
  localparam SLIP_TOP_W = 31 - `LDM_RXSLIP_HI;
  localparam SLIP_MID_W = `LDM_RXSLIP_LO - `LDM_TXEN_BIT - 1;
  localparam IRQ_PAD_W = 32 - `LDM_IRQ_W;

  ////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order
  // a new address waits until the response has been taken
  assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_r && !s_axi_bvalid;
  assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      awHeld_r <= 1'b0;
      awAddr_r <= {`LDM_ADDR_W{1'b0}};
      wHeld_r <= 1'b0;
      wData_r <= 32'h0;
      wStrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LDM_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= isMapped(awAddr_r) ? `LDM_RESP_OKAY : `LDM_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // software-written fields; reserved bits are never stored
  wire [31:0] wMerged = strobeMerge(32'h0, wData_r, wStrb_r);
  wire [31:0] extOld = {period_r, 24'h0};
  wire [31:0] slipOld = {26'h0, txEn_r, txSlip_r};
  wire [31:0] extNew = strobeMerge(extOld, wData_r, wStrb_r);
  wire [31:0] slipNew = strobeMerge(slipOld, wData_r, wStrb_r);

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      period_r <= 8'h00;
      txEn_r <= 1'b0;
      txSlip_r <= {`LDM_SLIP_W{1'b0}};
      mask_r <= {`LDM_IRQ_W{1'b0}};
    end
    else if (doWrite)
    begin
      if (hitOff(awAddr_r, `LDM_OFF_RXEXT))
        period_r <= extNew[`LDM_PER_HI:`LDM_PER_LO];
      if (hitOff(awAddr_r, `LDM_OFF_SLIP))
      begin
        txEn_r <= slipNew[`LDM_TXEN_BIT];
        txSlip_r <= slipNew[`LDM_SLIP_W-1:0];
      end
      // mask shares the event bit layout of the status word
      if (hitOff(awAddr_r, `LDM_OFF_IRQMSK))
        mask_r <= wMerged[`LDM_IRQ_W-1:0];
    end
  end

  assign rxMeasurePeriod = period_r;
  assign txSlipEnable = txEn_r;
  // downstream applies the amount only while txSlipEnable is high
  assign txSlipAmount = txSlip_r;

  ////////////////////////////////////////////////////////////////
  // read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign doRead = s_axi_arvalid && s_axi_arready;

  always @*
  begin
    rdWord = 32'h0;
    rdHit = 1'b1;
    if (hitOff(s_axi_araddr, `LDM_OFF_RXEXT))
      rdWord = {period_r, fresh_r, {EXT_PAD_W{1'b0}}, extLat_r};
    else if (hitOff(s_axi_araddr, `LDM_OFF_LOOP))
      rdWord = {{LOOP_PAD_W{1'b0}}, loopLat_r};
    else if (hitOff(s_axi_araddr, `LDM_OFF_SLIP))
      rdWord = {{SLIP_TOP_W{1'b0}}, rxSlip_r, {SLIP_MID_W{1'b0}}, txEn_r, txSlip_r};
    else if (hitOff(s_axi_araddr, `LDM_OFF_IRQST))
      rdWord = {{IRQ_PAD_W{1'b0}}, status};
    else if (hitOff(s_axi_araddr, `LDM_OFF_IRQMSK))
      rdWord = {{IRQ_PAD_W{1'b0}}, mask_r};
    else
      rdHit = 1'b0;
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `LDM_RESP_OKAY;
    end
    else if (doRead)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdWord;
      s_axi_rresp <= rdHit ? `LDM_RESP_OKAY : `LDM_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // extended latency result and its fresh flag
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fresh_r <= 1'b0;
      extLat_r <= {`LDM_RXBUF_DEPTH{1'b0}};
    end
    else
    begin
      if (rxExtResultStrobe)
        extLat_r <= rxExtResultValue;
      // a new result in the read cycle survives the clear
      if (rxExtResultStrobe)
        fresh_r <= 1'b1;
      else if (doRead && hitOff(s_axi_araddr, `LDM_OFF_RXEXT))
        fresh_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // loop latency: count from tx frame pulse to rx frame pulse
  // a tx pulse mid-count restarts it; the stored value stands until an rx pulse ends a running count
  assign loopDone = loopRun_r && rxFramePulse;
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      loopRun_r <= 1'b0;
      loopCnt_r <= {`LDM_LOOP_W{1'b0}};
      loopLat_r <= {`LDM_LOOP_W{1'b0}};
    end
    else
    begin
      if (txFramePulse)
      begin
        loopRun_r <= 1'b1;
        loopCnt_r <= {`LDM_LOOP_W{1'b0}};
      end
      else if (loopDone)
        loopRun_r <= 1'b0;
      else if (loopRun_r && ~&loopCnt_r)
        loopCnt_r <= loopCnt_r + 1'b1; // saturates rather than wrapping
      if (loopDone && !txFramePulse)
        loopLat_r <= loopCnt_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // receive slip capture, gated to sync or comma moves
  assign slipUpdate = frameSyncReset || (alignActive && commaMoved);
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rxSlip_r <= {`LDM_SLIP_W{1'b0}};
    else if (slipUpdate)
      rxSlip_r <= rxSlipDetected;
  end

  ////////////////////////////////////////////////////////////////
  ldm_event_flags ldm_event_flags_inst
  (
    .clk(clk),
    .resetn(resetn),
    .evtSet({slipUpdate && (rxSlipDetected != rxSlip_r), loopDone && !txFramePulse,
      rxExtResultStrobe}),
    .clrMask(wMerged[`LDM_IRQ_W-1:0]),
    .clrStrobe(doWrite && hitOff(awAddr_r, `LDM_OFF_IRQST)),
    .maskVal(mask_r),
    .status_r(status),
    .irq(irq)
  );
endmodule // ldm_regs

//--- bench/ldm_regs_asserts.sv
`timescale 1ns/1ns
`include "ldm_defs.vh"
module ldm_regs_asserts
(
  // clock
  input wire clk,
  input wire resetn,
  // bus
  input wire [`LDM_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  // outputs
  input wire [7:0] rxMeasurePeriod,
  input wire txSlipEnable,
  input wire [`LDM_SLIP_W-1:0] txSlipAmount
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // address of the read now answered; arready is low while rvalid
  reg [`LDM_ADDR_W-1:0] ra_r;
  wire hit = ra_r inside {`LDM_OFF_RXEXT, `LDM_OFF_LOOP, `LDM_OFF_SLIP,
    `LDM_OFF_IRQST, `LDM_OFF_IRQMSK};
  always @(posedge clk or negedge resetn)
    if (!resetn)
      ra_r <= 0;
    else if (s_axi_arvalid && s_axi_arready)
      ra_r <= s_axi_araddr;
  sequence s_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_out(a); s_axi_rvalid && ra_r == a; endsequence
  property p_lat; s_take |=> s_axi_rvalid; endproperty
  property p_rh; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  property p_blk; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_per; s_out(`LDM_OFF_RXEXT) |-> s_axi_rdata[31:24] == rxMeasurePeriod; endproperty
  property p_ext; s_out(`LDM_OFF_RXEXT) |-> s_axi_rdata[22:`LDM_RXBUF_DEPTH] == 0; endproperty
  property p_loop; s_out(`LDM_OFF_LOOP) |-> s_axi_rdata[31:20] == 0; endproperty
  property p_slip; s_out(`LDM_OFF_SLIP) |-> s_axi_rdata[15:0] == {txSlipEnable, txSlipAmount}
    && s_axi_rdata[31:21] == 0; endproperty
  property p_unm; s_axi_rvalid && !hit |-> s_axi_rresp == `LDM_RESP_SLVERR && s_axi_rdata == 0;
  endproperty
  a_lat: assert property (p_lat) else $error("read answer late");
  a_rh: assert property (p_rh) else $error("read answer dropped");
  a_bh: assert property (p_bh) else $error("write answer dropped");
  a_blk: assert property (p_blk) else $error("second read taken");
  a_per: assert property (p_per) else $error("period field mismatch");
  a_ext: assert property (p_ext) else $error("reserved bits set");
  a_loop: assert property (p_loop) else $error("loop high bits set");
  a_slip: assert property (p_slip) else $error("slip control mismatch");
  a_unm: assert property (p_unm) else $error("unmapped read answer");
endmodule // ldm_regs_asserts
bind ldm_regs ldm_regs_asserts ldm_regs_asserts_inst (.clk, .resetn, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .rxMeasurePeriod, .txSlipEnable, .txSlipAmount);

//--- bench/ldm_regs_test.sv
`timescale 1ns/1ns
`include "ldm_defs.vh"
`define CHK(a,b) begin testsRun++; if ((a)!==(b)) begin errorCnt++; \
  $display("unexpected %0t got %h want %h", $time, a, b); end end
module ldm_regs_test;
  logic clk=0, resetn=0, s_axi_awvalid=0, s_axi_wvalid=0, s_axi_bready=0;
  logic s_axi_arvalid=0, s_axi_rready=0, rxExtResultStrobe=0, txFramePulse=0;
  logic rxFramePulse=0, frameSyncReset=0, alignActive=0, commaMoved=0, slow=0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [7:0] s_axi_awaddr=0, s_axi_araddr=0, rxMeasurePeriod;
  logic [31:0] s_axi_wdata=0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb=0, rxExtResultValue=0;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [4:0] rxSlipDetected=0, txSlipAmount;
  logic txSlipEnable;
  int errorCnt=0, testsRun=0, cyc=0;
  ldm_regs ldm_regs_inst (.clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .rxExtResultStrobe, .rxExtResultValue, .rxMeasurePeriod,
    .txFramePulse, .rxFramePulse, .frameSyncReset, .alignActive, .commaMoved, .rxSlipDetected,
    .txSlipEnable, .txSlipAmount, .irq);
  initial forever #10 clk = ~clk;
  task giveVerdict;
    if (errorCnt == 0 && testsRun > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      errorCnt++;
      giveVerdict;
    end
  end
  task wr(input [7:0] a, input [31:0] v, input [3:0] s);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= !slow;
    forever
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_bvalid) s_axi_bready <= 1;
    end
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task rd(input [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= !slow;
    forever
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task ck(input [7:0] a, input [31:0] e);
    rd(a);
    `CHK(d, e)
  endtask
  // rx pulse seen k edges after the tx pulse
  task fr(input int k);
    @(posedge clk) txFramePulse <= 1;
    @(posedge clk) txFramePulse <= 0;
    repeat (k-1) @(posedge clk);
    rxFramePulse <= 1;
    @(posedge clk) rxFramePulse <= 0;
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    resetn <= 1;
    ck(`LDM_OFF_RXEXT, 0);
    ck(`LDM_OFF_LOOP, 0);
    ck(`LDM_OFF_SLIP, 0);
    wr(`LDM_OFF_RXEXT, 32'hFFFFFFFF, 4'hF);
    ck(`LDM_OFF_RXEXT, 32'hFF000000);
    `CHK(rxMeasurePeriod, 8'hFF)
    @(posedge clk) rxExtResultValue <= 4'hA;
    rxExtResultStrobe <= 1;
    @(posedge clk) rxExtResultStrobe <= 0;
    ck(`LDM_OFF_RXEXT, 32'hFF80000A);
    ck(`LDM_OFF_RXEXT, 32'hFF00000A);
    slow = 1;
    ck(`LDM_OFF_IRQST, 32'h1);
    `CHK(irq, 1'b0)
    wr(`LDM_OFF_IRQMSK, 32'h7, 4'hF);
    slow = 0;
    `CHK(irq, 1'b1)
    ck(`LDM_OFF_IRQMSK, 32'h7);
    wr(`LDM_OFF_IRQST, 32'h1, 4'hF);
    `CHK(irq, 1'b0)
    fr(7);
    ck(`LDM_OFF_LOOP, 32'h7);
    fr(3);
    ck(`LDM_OFF_LOOP, 32'h3);
    `CHK(irq, 1'b1)
    @(posedge clk) rxSlipDetected <= 5'h13;
    alignActive <= 1;
    ck(`LDM_OFF_SLIP, 0);
    @(posedge clk) commaMoved <= 1;
    @(posedge clk) commaMoved <= 0;
    ck(`LDM_OFF_SLIP, 32'h00130000);
    @(posedge clk) rxSlipDetected <= 5'h04;
    ck(`LDM_OFF_SLIP, 32'h00130000);
    @(posedge clk) frameSyncReset <= 1;
    @(posedge clk) frameSyncReset <= 0;
    ck(`LDM_OFF_SLIP, 32'h00040000);
    ck(`LDM_OFF_IRQST, 32'h6);
    wr(`LDM_OFF_SLIP, 32'hFFFFFF33, 4'hF);
    ck(`LDM_OFF_SLIP, 32'h00040033);
    `CHK({txSlipEnable, txSlipAmount}, 6'h33)
    wr(`LDM_OFF_SLIP, 32'h9, 4'h1);
    `CHK({txSlipEnable, txSlipAmount}, 6'h09)
    rd(8'h60);
    `CHK({r, d}, {`LDM_RESP_SLVERR, 32'h0})
    wr(8'h60, 32'h1, 4'hF);
    `CHK(r, `LDM_RESP_SLVERR)
    giveVerdict;
  end
endmodule // ldm_regs_test
